// [hw/mda_defines.vh]
`ifndef MDA_DEFINES_VH
`define MDA_DEFINES_VH
// ==========================================================
// Data memory locations
`define MDA_LOC_IND0     8'h00
`define MDA_LOC_PTR0     8'h01
`define MDA_LOC_IND1     8'h02
`define MDA_LOC_PTR1     8'h03
`define MDA_LOC_BANK     8'h04
`define MDA_LOC_WREG     8'h05
`define MDA_LOC_FLAGS    8'h0a
`define MDA_LOC_GP       8'h20
`define MDA_LOC_USB_LO   8'h41
`define MDA_LOC_USB_HI   8'h4a
`define MDA_USB_PAGE     4'h4
// ==========================================================
// Bus map
`define MDA_BUS_MEM_END  32'h00000400
`define MDA_BUS_CMD      32'h00000400
`define MDA_BUS_EVT      32'h00000404
`define MDA_HSIZE_WORD   3'h2
`define MDA_HRESP_OKAY   1'h0
// ==========================================================
// Flag bit positions
`define MDA_FL_C         0
`define MDA_FL_HC        1
`define MDA_FL_Z         2
`define MDA_FL_SW        3
// ==========================================================
// Command and event fields
`define MDA_CMD_OP_LSB   0
`define MDA_CMD_OP_MSB   3
`define MDA_CMD_LOC_LSB  4
`define MDA_CMD_LOC_MSB  11
`define MDA_CMD_DST      12
`define MDA_EVT_HALT     0
`define MDA_EVT_WDCLR    1
// ==========================================================
// Operation codes
`define MDA_OP_ADD       4'h0
`define MDA_OP_ADC       4'h1
`define MDA_OP_SUB       4'h2
`define MDA_OP_SBC       4'h3
`define MDA_OP_DADJ      4'h4
`define MDA_OP_AND       4'h5
`define MDA_OP_OR        4'h6
`define MDA_OP_XOR       4'h7
`define MDA_OP_CPL       4'h8
`define MDA_OP_RL        4'h9
`define MDA_OP_RR        4'ha
`define MDA_OP_RLC       4'hb
`define MDA_OP_RRC       4'hc
`define MDA_OP_INC       4'hd
`define MDA_OP_DEC       4'he
`define MDA_OP_MOVE      4'hf
// ==========================================================
// Reset values
`define MDA_RST_BYTE     8'h00
`define MDA_RST_ARITH    4'h0
`define MDA_RST_BIT      1'h0
`define MDA_RST_CMD      13'h0000
`endif

// [hw/mda_ram.v]
`default_nettype none
// ==========================================================
// Simple dual-port store, registered read
module mda_ram #(
    parameter ADDR_W = 8,
    parameter DATA_W = 8
) (
    input  wire              ref_clk_i,
    input  wire              ce_i,
    input  wire              we_i,
    input  wire [ADDR_W-1:0] waddr_i,
    input  wire [DATA_W-1:0] wdata_i,
    input  wire [ADDR_W-1:0] raddr_i,
    output reg  [DATA_W-1:0] rdata_o
);
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Contents are not reset; software must initialise them
    always @(posedge ref_clk_i)
    begin
        if (ce_i)
        begin
            if (we_i)
            begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end
endmodule
`default_nettype wire

// [hw/mda_alu.v]
`include "mda_defines.vh"
`default_nettype none
// ==========================================================
// Combinational 8-bit ALU, reports which flags it touches
module mda_alu (
    input  wire [3:0] op_i,
    input  wire [7:0] wreg_i,
    input  wire [7:0] opd_i,
    input  wire       carry_i,
    input  wire       half_i,
    output reg  [7:0] result_o,
    output reg  [3:0] mask_o,
    output reg  [3:0] flag_o
);
    reg [7:0] bb;
    reg [7:0] ci;
    reg [8:0] sum;
    reg [4:0] lo;
    reg [7:0] low7;
    reg [8:0] dadj;

    always @*
    begin
        bb = ((op_i == `MDA_OP_SUB) || (op_i == `MDA_OP_SBC)) ? ~opd_i : opd_i;
        ci = (op_i == `MDA_OP_ADD) ? 8'h00 :
             (op_i == `MDA_OP_SUB) ? 8'h01 : {7'h00, carry_i};
        sum = {1'b0, wreg_i} + {1'b0, bb} + {1'b0, ci};
        lo = {1'b0, wreg_i[3:0]} + {1'b0, bb[3:0]} + ci[4:0];
        low7 = {1'b0, wreg_i[6:0]} + {1'b0, bb[6:0]} + ci;
        dadj = {1'b0, wreg_i};
        if ((wreg_i[3:0] > 4'h9) || half_i)
        begin
            dadj = dadj + 9'h006;
        end
        if ((dadj[7:4] > 4'h9) || carry_i || dadj[8])
        begin
            dadj = dadj + 9'h060;
        end
        result_o = opd_i;
        mask_o = 4'h0;
        flag_o = 4'h0;
        case (op_i)
            `MDA_OP_ADD, `MDA_OP_ADC, `MDA_OP_SUB, `MDA_OP_SBC:
            begin
                // Carry is "no borrow" on subtract since bb is inverted
                result_o = sum[7:0];
                mask_o = 4'hf;
                flag_o[`MDA_FL_C] = sum[8];
                flag_o[`MDA_FL_HC] = lo[4];
                flag_o[`MDA_FL_SW] = low7[7] ^ sum[8];
            end
            `MDA_OP_DADJ:
            begin
                result_o = dadj[7:0];
                mask_o[`MDA_FL_C] = 1'b1;
                flag_o[`MDA_FL_C] = carry_i | dadj[8] | (wreg_i > 8'h99);
            end
            `MDA_OP_AND:
            begin
                result_o = wreg_i & opd_i;
                mask_o[`MDA_FL_Z] = 1'b1;
            end
            `MDA_OP_OR:
            begin
                result_o = wreg_i | opd_i;
                mask_o[`MDA_FL_Z] = 1'b1;
            end
            `MDA_OP_XOR:
            begin
                result_o = wreg_i ^ opd_i;
                mask_o[`MDA_FL_Z] = 1'b1;
            end
            `MDA_OP_CPL:
            begin
                result_o = ~opd_i;
                mask_o[`MDA_FL_Z] = 1'b1;
            end
            `MDA_OP_RL:  result_o = {opd_i[6:0], opd_i[7]};
            `MDA_OP_RR:  result_o = {opd_i[0], opd_i[7:1]};
            `MDA_OP_RLC:
            begin
                result_o = {opd_i[6:0], carry_i};
                mask_o[`MDA_FL_C] = 1'b1;
                flag_o[`MDA_FL_C] = opd_i[7];
            end
            `MDA_OP_RRC:
            begin
                result_o = {carry_i, opd_i[7:1]};
                mask_o[`MDA_FL_C] = 1'b1;
                flag_o[`MDA_FL_C] = opd_i[0];
            end
            `MDA_OP_INC:
            begin
                result_o = opd_i + 8'h01;
                mask_o[`MDA_FL_Z] = 1'b1;
            end
            `MDA_OP_DEC:
            begin
                result_o = opd_i - 8'h01;
                mask_o[`MDA_FL_Z] = 1'b1;
            end
            default:     result_o = opd_i;
        endcase
        flag_o[`MDA_FL_Z] = (result_o == 8'h00);
    end
endmodule
`default_nettype wire

// [hw/mda_core.v]
// The AHB-Lite register port was chosen for this implementation.
`include "mda_defines.vh"
`default_nettype none
module mda_core #(
    parameter GP_ADDR_W  = 8,
    parameter USB_ADDR_W = 4
) (
    input  wire        ref_clk_i,
    input  wire        reset_i,
    input  wire        ce_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    input  wire        wdt_timeout_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    output reg  [7:0]  flags_o,
    output reg  [7:0]  working_register_o
);
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_DATA  = 2'h1;
    localparam [1:0] ST_RDOUT = 2'h2;
    localparam [1:0] ST_EXEC  = 2'h3;
    localparam [1:0] SEL_NONE = 2'h0;
    localparam [1:0] SEL_MEM  = 2'h1;
    localparam [1:0] SEL_CMD  = 2'h2;
    localparam [1:0] SEL_EVT  = 2'h3;

    // ==========================================================
    // Location resolution
    function is_ind;
        input [7:0] a;
        begin
            is_ind = (a == `MDA_LOC_IND0) || (a == `MDA_LOC_IND1);
        end
    endfunction

    // Result is {null, bank, addr}; null marks indirect-to-indirect
    function [9:0] resolve;
        input [7:0] loc;
        input [7:0] p0;
        input [7:0] p1;
        input       bk;
        begin
            resolve = {2'b00, loc};
            if (loc == `MDA_LOC_IND0)
            begin
                resolve = {is_ind(p0), 1'b0, p0};
            end
            else if (loc == `MDA_LOC_IND1)
            begin
                resolve = {is_ind(p1), bk, p1};
            end
        end
    endfunction

    function in_usb;
        input [7:0] a;
        begin
            in_usb = (a >= `MDA_LOC_USB_LO) && (a <= `MDA_LOC_USB_HI);
        end
    endfunction

    // ==========================================================
    // State
    reg [1:0]  state_ff;
    reg [1:0]  sel_ff;
    reg        write_ff;
    reg [7:0]  loc_ff;
    reg [9:0]  tgt_ff;
    reg [7:0]  ptr0_ff;
    reg [7:0]  ptr1_ff;
    reg        bank_ff;
    reg [7:0]  wreg_ff;
    reg [3:0]  arith_ff;
    reg        sleep_ff;
    reg        expiry_ff;
    reg [12:0] cmd_ff;

    reg [1:0]  nxt_state;
    reg [1:0]  nxt_sel;
    reg        nxt_write;
    reg [7:0]  nxt_loc;
    reg [9:0]  nxt_tgt;
    reg [7:0]  nxt_ptr0;
    reg [7:0]  nxt_ptr1;
    reg        nxt_bank;
    reg [7:0]  nxt_wreg;
    reg [3:0]  nxt_arith;
    reg        nxt_sleep;
    reg        nxt_expiry;
    reg [12:0] nxt_cmd;
    reg        nxt_hready;
    reg [31:0] nxt_hrdata;

    reg        wr_en;
    reg [9:0]  wr_tgt;
    reg [7:0]  wr_data;
    reg [7:0]  tgt_val;
    reg        do_halt;
    reg        do_clr;

    wire [9:0] res_bus;
    wire [9:0] res_cmd;
    wire [9:0] rd_tgt;
    wire [7:0] gp_rdata;
    wire [7:0] usb_rdata;
    wire [7:0] alu_res;
    wire [3:0] alu_mask;
    wire [3:0] alu_flag;
    wire       accept;
    wire       ram_gp_we;
    wire       ram_usb_we;
    wire       cmd_to_mem;

    assign res_bus = resolve(loc_ff, ptr0_ff, ptr1_ff, bank_ff);
    assign res_cmd = resolve(hwdata_i[`MDA_CMD_LOC_MSB:`MDA_CMD_LOC_LSB],
                             ptr0_ff, ptr1_ff, bank_ff);
    assign rd_tgt = (sel_ff == SEL_CMD) ? res_cmd : res_bus;
    assign accept = hsel_i && htrans_i[1] && hready_i && (state_ff == ST_IDLE);
    assign cmd_to_mem = cmd_ff[`MDA_CMD_DST];

    // ==========================================================
    // Storage and ALU
    // bank 0 and bank 1 write gates
    assign ram_gp_we = wr_en && !wr_tgt[9] && !wr_tgt[8] && (wr_tgt[7:0] >= `MDA_LOC_GP);
    assign ram_usb_we = wr_en && !wr_tgt[9] && wr_tgt[8] && in_usb(wr_tgt[7:0]);

    mda_ram #(
        .ADDR_W (GP_ADDR_W),
        .DATA_W (8)
    ) u_gp_ram (
        .ref_clk_i (ref_clk_i),
        .ce_i      (ce_i),
        .we_i      (ram_gp_we),
        .waddr_i   (wr_tgt[GP_ADDR_W-1:0]),
        .wdata_i   (wr_data),
        .raddr_i   (rd_tgt[GP_ADDR_W-1:0]),
        .rdata_o   (gp_rdata)
    );

    mda_ram #(
        .ADDR_W (USB_ADDR_W),
        .DATA_W (8)
    ) u_usb_ram (
        .ref_clk_i (ref_clk_i),
        .ce_i      (ce_i),
        .we_i      (ram_usb_we),
        .waddr_i   (wr_tgt[USB_ADDR_W-1:0]),
        .wdata_i   (wr_data),
        .raddr_i   (rd_tgt[USB_ADDR_W-1:0]),
        .rdata_o   (usb_rdata)
    );

    mda_alu u_alu (
        .op_i     (cmd_ff[`MDA_CMD_OP_MSB:`MDA_CMD_OP_LSB]),
        .wreg_i   (wreg_ff),
        .opd_i    (tgt_val),
        .carry_i  (arith_ff[`MDA_FL_C]),
        .half_i   (arith_ff[`MDA_FL_HC]),
        .result_o (alu_res),
        .mask_o   (alu_mask),
        .flag_o   (alu_flag)
    );

    // ==========================================================
    // Read mux over the resolved target
    always @*
    begin
        tgt_val = 8'h00;
        if (tgt_ff[9])
        begin
            tgt_val = 8'h00;
        end
        else if (tgt_ff[7:0] < `MDA_LOC_GP)
        begin
            case (tgt_ff[7:0])
                `MDA_LOC_PTR0:  tgt_val = ptr0_ff;
                `MDA_LOC_PTR1:  tgt_val = ptr1_ff;
                `MDA_LOC_BANK:  tgt_val = {7'h00, bank_ff};
                `MDA_LOC_WREG:  tgt_val = wreg_ff;
                `MDA_LOC_FLAGS: tgt_val = {2'b00, expiry_ff, sleep_ff, arith_ff};
                default:        tgt_val = 8'h00;
            endcase
        end
        else if (!tgt_ff[8])
        begin
            tgt_val = gp_rdata;
        end
        else if (in_usb(tgt_ff[7:0]))
        begin
            tgt_val = usb_rdata;
        end
    end

    // ==========================================================
    // Bus sequencer
    always @*
    begin
        nxt_state = state_ff;
        nxt_sel = sel_ff;
        nxt_write = write_ff;
        nxt_loc = loc_ff;
        nxt_tgt = tgt_ff;
        nxt_cmd = cmd_ff;
        nxt_hready = hreadyout_o;
        nxt_hrdata = hrdata_o;
        wr_en = 1'b0;
        wr_tgt = res_bus;
        wr_data = hwdata_i[7:0];
        do_halt = 1'b0;
        do_clr = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                if (accept)
                begin
                    nxt_state = ST_DATA;
                    nxt_hready = 1'b0;
                    nxt_write = hwrite_i;
                    nxt_loc = haddr_i[9:2];
                    if (hsize_i != `MDA_HSIZE_WORD)
                        nxt_sel = SEL_NONE;
                    else if ((haddr_i < `MDA_BUS_MEM_END) && (haddr_i[1:0] == 2'b00))
                        nxt_sel = SEL_MEM;
                    else if (haddr_i == `MDA_BUS_CMD)
                        nxt_sel = SEL_CMD;
                    else if (haddr_i == `MDA_BUS_EVT)
                        nxt_sel = SEL_EVT;
                    else
                        nxt_sel = SEL_NONE;
                end
            end
            ST_DATA:
            begin
                nxt_state = ST_IDLE;
                nxt_hready = 1'b1;
                nxt_hrdata = 32'h00000000;
                nxt_tgt = rd_tgt;
                case (sel_ff)
                    SEL_MEM:
                    begin
                        if (write_ff)
                            wr_en = 1'b1;
                        else
                        begin
                            nxt_state = ST_RDOUT;
                            nxt_hready = 1'b0;
                        end
                    end
                    SEL_CMD:
                    begin
                        if (write_ff)
                        begin
                            nxt_cmd = hwdata_i[12:0];
                            nxt_state = ST_EXEC;
                            nxt_hready = 1'b0;
                        end
                        else
                            nxt_hrdata = {19'h00000, cmd_ff};
                    end
                    SEL_EVT:
                    begin
                        do_halt = write_ff && hwdata_i[`MDA_EVT_HALT];
                        do_clr = write_ff && hwdata_i[`MDA_EVT_WDCLR];
                    end
                    default:
                    begin
                        nxt_hrdata = 32'h00000000;
                    end
                endcase
            end
            ST_RDOUT:
            begin
                nxt_state = ST_IDLE;
                nxt_hready = 1'b1;
                nxt_hrdata = {24'h000000, tgt_val};
            end
            ST_EXEC:
            begin
                nxt_state = ST_IDLE;
                nxt_hready = 1'b1;
                wr_en = cmd_to_mem;
                wr_tgt = tgt_ff;
                wr_data = (cmd_ff[`MDA_CMD_OP_MSB:`MDA_CMD_OP_LSB] == `MDA_OP_MOVE) ?
                          wreg_ff : alu_res;
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_hready = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // Register write decode and flag update
    always @*
    begin
        nxt_ptr0 = ptr0_ff;
        nxt_ptr1 = ptr1_ff;
        nxt_bank = bank_ff;
        nxt_wreg = wreg_ff;
        nxt_arith = arith_ff;
        nxt_sleep = sleep_ff;
        nxt_expiry = expiry_ff;
        if (wr_en && !wr_tgt[9] && (wr_tgt[7:0] < `MDA_LOC_GP))
        begin
            case (wr_tgt[7:0])
                `MDA_LOC_PTR0:  nxt_ptr0 = wr_data;
                `MDA_LOC_PTR1:  nxt_ptr1 = wr_data;
                `MDA_LOC_BANK:  nxt_bank = wr_data[0];
                `MDA_LOC_WREG:  nxt_wreg = wr_data;
                `MDA_LOC_FLAGS: nxt_arith = wr_data[3:0];
                default:        nxt_arith = nxt_arith;
            endcase
        end
        if (state_ff == ST_EXEC)
        begin
            if (!cmd_to_mem)
                nxt_wreg = alu_res;
            nxt_arith = (nxt_arith & ~alu_mask) | (alu_flag & alu_mask);
        end
        if (do_clr)
            nxt_sleep = 1'b0;
        if (do_halt)
            nxt_sleep = 1'b1;
        // expiry flag, timeout wins over clears
        if (do_clr || do_halt)
            nxt_expiry = 1'b0;
        if (wdt_timeout_i)
            nxt_expiry = 1'b1;
    end

    // ==========================================================
    // Flops
    // Flags kept only here; nothing saves them on a call
    always @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_ff <= ST_IDLE;
            sel_ff <= SEL_NONE;
            write_ff <= 1'b0;
            loc_ff <= `MDA_RST_BYTE;
            tgt_ff <= 10'h000;
            ptr0_ff <= `MDA_RST_BYTE;
            ptr1_ff <= `MDA_RST_BYTE;
            bank_ff <= `MDA_RST_BIT;
            wreg_ff <= `MDA_RST_BYTE;
            arith_ff <= `MDA_RST_ARITH;
            sleep_ff <= `MDA_RST_BIT;
            expiry_ff <= `MDA_RST_BIT;
            cmd_ff <= `MDA_RST_CMD;
            hreadyout_o <= 1'b1;
            hrdata_o <= 32'h00000000;
            hresp_o <= `MDA_HRESP_OKAY;
            flags_o <= 8'h00;
            working_register_o <= `MDA_RST_BYTE;
        end
        else if (ce_i)
        begin
            state_ff <= nxt_state;
            sel_ff <= nxt_sel;
            write_ff <= nxt_write;
            loc_ff <= nxt_loc;
            tgt_ff <= nxt_tgt;
            ptr0_ff <= nxt_ptr0;
            ptr1_ff <= nxt_ptr1;
            bank_ff <= nxt_bank;
            wreg_ff <= nxt_wreg;
            arith_ff <= nxt_arith;
            sleep_ff <= nxt_sleep;
            expiry_ff <= nxt_expiry;
            cmd_ff <= nxt_cmd;
            hreadyout_o <= nxt_hready;
            hrdata_o <= nxt_hrdata;
            hresp_o <= `MDA_HRESP_OKAY;
            // Mirrors are one cycle behind the internal state
            flags_o <= {2'b00, expiry_ff, sleep_ff, arith_ff};
            working_register_o <= wreg_ff;
        end
    end
endmodule
`default_nettype wire

// [verif/mda_core_sva.sv]
`default_nettype none
module mda_core_sva (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic        ce_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [2:0]  hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic        wdt_timeout_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [7:0]  flags_o,
    input wire logic [7:0]  working_register_o
);
    logic wr_take;
    logic evt_take;
    assign wr_take = hsel_i && htrans_i[1] && hready_i && hwrite_i && hsize_i == 3'h2;
    assign evt_take = wr_take && haddr_i == 32'h404;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    // ==========
    // Sequences
    sequence s_one_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    sequence s_wreg_wr;
        wr_take && haddr_i == 32'h14 ##1 1'b1;
    endsequence
    // Timeout in the write's data cycle would move bit 5 legally
    sequence s_flag_wr;
        wr_take && haddr_i == 32'h28 ##1 !wdt_timeout_i ##2 1'b1;
    endsequence
    // ==========
    // Properties
    property p_wr_lat;
        wr_take && haddr_i < 32'h400 |=> s_one_wait;
    endproperty
    property p_wreg;
        s_wreg_wr |-> ##2 {24'h0, working_register_o} == ($past(hwdata_i, 2) & 32'hff);
    endproperty
    property p_top0;
        flags_o[7:6] == 2'h0;
    endproperty
    property p_rst;
        disable iff (1'b0) reset_i |=> flags_o == 8'h00;
    endproperty
    property p_wdt_set;
        wdt_timeout_i && ce_i |-> ##2 flags_o[5];
    endproperty
    property p_wdt_src;
        $rose(flags_o[5]) |-> $past(wdt_timeout_i, 2);
    endproperty
    property p_sleep_src;
        $changed(flags_o[4]) && !$past(reset_i) |-> $past(evt_take, 3);
    endproperty
    property p_flag_wr;
        s_flag_wr |-> $stable(flags_o[5:4]);
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("Write wait wrong");
    a_wreg: assert property (p_wreg) else $error("Working reg not written");
    a_top0: assert property (p_top0) else $error("Flag bits 7:6 set");
    a_rst: assert property (p_rst) else $error("Flags not cleared");
    a_wdt_set: assert property (p_wdt_set) else $error("Expiry not set");
    a_wdt_src: assert property (p_wdt_src) else $error("Expiry set alone");
    a_sleep_src: assert property (p_sleep_src) else $error("Sleep moved alone");
    a_flag_wr: assert property (p_flag_wr) else $error("Write hit bits 5:4");
endmodule
bind mda_core mda_core_sva i_sva (
    .ref_clk_i, .reset_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i, .wdt_timeout_i, .hrdata_o, .hreadyout_o,
    .hresp_o, .flags_o, .working_register_o
);
`default_nettype wire

// [verif/tb_mda_core.sv]
`include "mda_defines.vh"
`default_nettype none
module tb_mda_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst;
    logic        hsel;
    logic        hwrite;
    logic        wdt;
    logic        ce;
    logic        hrdy;
    logic        hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [7:0]  flg;
    logic [7:0]  wreg;
    int          fails = 0;
    int          checked = 0;
    // Op, preset flags, A, B, result, flags
    localparam logic [35:0] ALU_T [18] = '{
        36'h0_0_0f_01_10_2, 36'h0_0_80_80_00_d, 36'h1_1_7f_00_80_a,
        36'h2_0_05_05_00_7, 36'h2_f_00_01_ff_0, 36'h3_0_10_01_0e_1,
        36'h4_0_aa_00_10_1, 36'h5_0_f0_0f_00_4, 36'h6_4_50_0a_5a_0,
        36'h7_0_ff_ff_00_4, 36'h8_0_00_ff_00_4, 36'h9_f_00_81_03_f,
        36'ha_0_00_81_c0_0, 36'hb_0_00_80_00_1, 36'hc_1_00_01_80_1,
        36'hd_0_00_ff_00_4, 36'he_1_00_01_00_5, 36'hf_0_00_3c_3c_0
    };
    mda_core i_dut (
        .ref_clk_i(clk), .reset_i(rst), .ce_i(ce), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(`MDA_HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hrdy),
        .wdt_timeout_i(wdt), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .flags_o(flg), .working_register_o(wreg)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========
    // Bus helpers
    function automatic logic [31:0] la(input logic [7:0] l);
        return {22'h0, l, 2'h0};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    // Reads see hready before the edge's updates land
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'b1)
            @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1)
            @(posedge clk);
        q = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input string n, input logic [31:0] a, e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(n, q, e);
    endtask
    task automatic pulse();
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
    endtask
    // ==========
    // Scenarios
    task automatic t_reset();
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd("bank sel", la(8'h04), 32'h0);
        rd("flags", la(8'h0a), 32'h0);
        chk("flags_o", {24'h0, flg}, 32'h0);
    endtask
    task automatic t_indirect();
        wr(la(8'h30), 32'h5a);
        wr(la(8'h01), 32'h30);
        rd("ind0 rd", la(8'h00), 32'h5a);
        wr(la(8'h00), 32'ha5);
        rd("ind0 wr", la(8'h30), 32'ha5);
        wr(la(8'h01), 32'hff);
        wr(la(8'h00), 32'h3c);
        rd("ptr top", la(8'hff), 32'h3c);
        wr(la(8'h03), 32'h00);
        rd("self rd", la(8'h02), 32'h0);
        wr(la(8'h02), 32'h77);
        rd("self wr", la(8'hff), 32'h3c);
        wr(la(8'h0c), 32'h12);
        rd("unused", la(8'h0c), 32'h0);
    endtask
    task automatic t_bank();
        wr(la(8'h41), 32'h11);
        wr(la(8'h04), 32'h01);
        wr(la(8'h03), 32'h41);
        wr(la(8'h02), 32'h99);
        rd("bank1", la(8'h02), 32'h99);
        rd("bank0 dir", la(8'h41), 32'h11);
        wr(la(8'h01), 32'h41);
        rd("ptr0 bank", la(8'h00), 32'h11);
        wr(la(8'h05), 32'h3e);
        wr(la(8'h03), 32'h05);
        rd("shared", la(8'h02), 32'h3e);
        wr(la(8'h04), 32'h00);
        wr(la(8'h03), 32'h41);
        rd("bank0 ind", la(8'h02), 32'h11);
    endtask
    task automatic t_alu();
        logic [35:0] r;
        for (int i = 0; i < 18; i++)
        begin
            r = ALU_T[i];
            wr(la(8'h0a), {28'h0, r[31:28]});
            wr(la(8'h05), {24'h0, r[27:20]});
            wr(la(8'h40), {24'h0, r[19:12]});
            wr(`MDA_BUS_CMD, {19'h0, 1'b0, 8'h40, r[35:32]});
            rd("alu res", la(8'h05), {24'h0, r[11:4]});
            rd("alu flags", la(8'h0a), {28'h0, r[3:0]});
            chk("wreg port", {24'h0, wreg}, {24'h0, r[11:4]});
        end
        wr(la(8'h40), 32'h7f);
        wr(`MDA_BUS_CMD, {19'h0, 1'b1, 8'h40, `MDA_OP_INC});
        rd("alu to loc", la(8'h40), 32'h80);
        wr(la(8'h05), 32'h66);
        wr(`MDA_BUS_CMD, {19'h0, 1'b1, 8'h41, `MDA_OP_MOVE});
        rd("move out", la(8'h41), 32'h66);
        rd("cmd rd", `MDA_BUS_CMD, 32'h141f);
    endtask
    task automatic t_status();
        wr(la(8'h0a), 32'hff);
        rd("flag wr", la(8'h0a), 32'h0f);
        pulse();
        rd("timeout", la(8'h0a), 32'h2f);
        chk("flags_o", {24'h0, flg}, 32'h2f);
        wr(`MDA_BUS_EVT, 32'h1);
        rd("halt", la(8'h0a), 32'h1f);
        pulse();
        wr(la(8'h0a), 32'h00);
        rd("keep 5:4", la(8'h0a), 32'h30);
        wr(`MDA_BUS_EVT, 32'h2);
        rd("wdt clear", la(8'h0a), 32'h00);
        // Time-out while frozen must be lost
        @(posedge clk);
        ce <= 1'b0;
        pulse();
        @(posedge clk);
        ce <= 1'b1;
        rd("ce freeze", la(8'h0a), 32'h00);
        pulse();
        // Leave bank 1 selected so the next reset is seen to clear it
        wr(la(8'h04), 32'h01);
    endtask
    task automatic end_sim();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        wdt = 1'b0;
        ce = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        t_reset();
        t_indirect();
        t_bank();
        t_alu();
        t_status();
        t_reset();
        end_sim();
    end
    // Whole run is near 750 cycles
    initial
    begin
        #150000;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
